// [dv/pvc_pll_ctrl_properties.sv]
// port assertions for the pll override and oscillator calibration block
`timescale 1ns/1ns
`include "pvc_defs.vh"
module pvc_pll_ctrl_chk #(
  parameter TRIM_W = 7
) (
  input wire              core_clk_i,
  input wire              rst_n_i,
  input wire              reg_wr_i,
  input wire              reg_rd_i,
  input wire [7:0]        reg_addr_i,
  input wire [7:0]        reg_wdata_i,
  input wire [7:0]        reg_rdata_o,
  input wire              pll_program_hold_o,
  input wire [TRIM_W-1:0] osc_freq_trim_o,
  input wire              osc_cal_done_o
);
  // offsets that answer a read; anything else must read as zero
  wire mapped = reg_addr_i inside {8'h58, 8'h59, 8'h5C, 8'h5D, 8'h5E};
  // single clock domain, so one default clock and reset
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  hold_write_a: assert property (reg_wr_i && reg_addr_i == `PVC_ADDR_PLL_HOLD |=>
    pll_program_hold_o == $past(reg_wdata_i[0])) else $error("hold bit missed a write");
  trim_write_a: assert property (reg_wr_i && reg_addr_i == `PVC_ADDR_OSC_TRIM
    && osc_cal_done_o |=> osc_freq_trim_o == $past(reg_wdata_i[TRIM_W-1:0]))
    else $error("trim write lost");
  trim_frozen_a: assert property (pll_program_hold_o && !reg_wr_i |=>
    $stable(osc_freq_trim_o)) else $error("trim moved while held");
  cal_start_a: assert property ($fell(osc_cal_done_o) |-> !pll_program_hold_o
    && osc_freq_trim_o == 7'h40) else $error("calibration start wrong");
  cal_min_a: assert property ($fell(osc_cal_done_o) |=> !osc_cal_done_o [*8])
    else $error("calibration ended too soon");
  done_rise_a: assert property ($rose(osc_cal_done_o) |-> !pll_program_hold_o)
    else $error("done set while held");
  rd_trim_a: assert property (reg_rd_i && reg_addr_i == `PVC_ADDR_OSC_TRIM |=>
    reg_rdata_o[TRIM_W-1:0] == $past(osc_freq_trim_o)) else $error("trim read wrong");
  rd_status_a: assert property (reg_rd_i && reg_addr_i == `PVC_ADDR_CAL_STATUS |=>
    reg_rdata_o == {7'h00, $past(osc_cal_done_o)}) else $error("status read wrong");
  rd_unmapped_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rd_stable_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
endmodule // pvc_pll_ctrl_chk
bind pvc_pll_ctrl pvc_pll_ctrl_chk #(.TRIM_W(TRIM_W)) u_chk (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .pll_program_hold_o(pll_program_hold_o), .osc_freq_trim_o(osc_freq_trim_o),
  .osc_cal_done_o(osc_cal_done_o));

// [dv/tb_top.sv]
// self-checking bench for the pll override and oscillator calibration block
`timescale 1ns/1ns
`include "pvc_defs.vh"
module tb_top;
  localparam [6:0] TGT = 7'h2B;  // trim where the comparator flips
  reg         core_clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         reg_wr_i = 1'b0;
  reg         reg_rd_i = 1'b0;
  reg  [7:0]  reg_addr_i = 8'h00;
  reg  [7:0]  reg_wdata_i = 8'h00;
  reg  [3:0]  pins_r = 4'h0;  // cfg_b, cfg_a, ref type, enable
  reg  [2:0]  rc_r = 3'h0;
  reg         fast_r = 1'b0;
  wire [7:0]  rdata;
  wire [6:0]  trim;
  wire        en, se, hold, done, outc;
  integer     err_total = 0;
  integer     n_compared = 0;
  integer     t0, t1, n, i;
  reg  [7:0]  d;
  // clock, reference at clk/8, and a comparator that is fast above TGT
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) rc_r <= rc_r + 3'h1;
  always @(posedge core_clk_i) fast_r <= (trim > TGT);
  pvc_pll_ctrl DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(rdata), .pll_enable_pin_i(pins_r[0]), .ref_type_select_pin_i(pins_r[1]),
    .clock_cfg_pin_a_i(pins_r[2]), .clock_cfg_pin_b_i(pins_r[3]), .pll_ref_clk_i(rc_r[2]),
    .osc_too_fast_i(fast_r), .pll_enable_o(en), .single_ended_ref_select_o(se),
    .pll_program_hold_o(hold), .osc_freq_trim_o(trim), .osc_cal_done_o(done),
    .ref_clock_out_c_o(outc));
  task end_of_test;
    begin
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // exact compare of a design value; x never matches
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
      end
    end
  endtask
  // count compare with a tolerance, for edges and cycle figures
  task chkn(input string nm, input integer e, input integer g, input integer tol);
    begin
      n_compared = n_compared + 1;
      if (g > e + tol || g < e - tol) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  // read data lands on the same edge that takes the strobe
  task rchk(input [7:0] a, input [7:0] e);
    begin
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 d = rdata;
      chk("read data", e, d);
    end
  endtask
  // rising edges of the reference output over 256 cycles (32 reference periods)
  task edges(output integer c);
    reg p;
    begin
      c = 0;
      p = outc;
      repeat (256) begin
        @(posedge core_clk_i);
        if (outc === 1'b1 && p === 1'b0) c = c + 1;
        p = outc;
      end
    end
  endtask
  // bounded wait for done; running out ends the run as a failure
  task wait_done(output integer c);
    begin
      c = 0;
      while (done !== 1'b1 && c < 20000) begin
        @(posedge core_clk_i);
        c = c + 1;
      end
      if (c >= 20000) begin
        err_total = err_total + 1;
        $display("CHECK FAILED done wait exp 1 got %b", done);
        end_of_test;
      end
    end
  endtask
  // hold the calibration off, program control, release the hold
  task run_cal(input [7:0] ctl);
    begin
      wr(`PVC_ADDR_PLL_HOLD, 8'h01);
      wr(`PVC_ADDR_CAL_CONTROL, ctl);
      wr(`PVC_ADDR_PLL_HOLD, 8'h00);
      @(posedge core_clk_i);
      #1;
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rchk(`PVC_ADDR_PIN_OVERRIDE, 8'h00);
    rchk(`PVC_ADDR_OSC_TRIM, 8'h00);
    rchk(`PVC_ADDR_PLL_HOLD, 8'h00);
    rchk(`PVC_ADDR_CAL_CONTROL, 8'h40);
    rchk(8'h60, 8'h00);
    $display("test reset values done");
    // pin mode: field asks for undivided, pins ask for a quarter
    @(posedge core_clk_i) pins_r <= 4'hF;
    wr(`PVC_ADDR_PIN_OVERRIDE, 8'h04);
    repeat (4) @(posedge core_clk_i);
    #1 chk("pll enable", 8'h01, {7'h00, en});
    chk("se select", 8'h01, {7'h00, se});
    edges(n);
    chkn("ref out edges", 8, n, 1);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`PVC_ADDR_PIN_OVERRIDE, {4'h8, i[1:0], 2'b00});
      edges(n);
      chkn("ref out edges", (i == 0) ? 0 : 32 >> (i - 1), n, 1);
    end
    chk("pll enable", 8'h00, {7'h00, en});
    chk("se select", 8'h00, {7'h00, se});
    @(posedge core_clk_i) pins_r <= 4'h0;
    wr(`PVC_ADDR_PIN_OVERRIDE, 8'h83);
    #1 chk("pll enable", 8'h01, {7'h00, en});
    chk("se select", 8'h01, {7'h00, se});
    $display("test pin override done");
    // disabled calibration is skipped and leaves the trim alone
    wr(`PVC_ADDR_OSC_TRIM, 8'h15);
    rchk(`PVC_ADDR_OSC_TRIM, 8'h15);
    run_cal(8'h00);
    chk("done", 8'h01, {7'h00, done});
    chk("trim", 8'h15, {1'b0, trim});
    rchk(`PVC_ADDR_CAL_STATUS, 8'h01);
    $display("test skipped calibration done");
    // shortest settle, then one step longer; trim must land on the centre
    run_cal(8'h01);
    chk("done", 8'h00, {7'h00, done});
    chk("trim", 8'h40, {1'b0, trim});
    wait_done(t0);
    chkn("trim centre", TGT, trim, 1);
    rchk(`PVC_ADDR_CAL_CONTROL, 8'h01);
    rchk(`PVC_ADDR_OSC_TRIM, {1'b0, TGT});
    run_cal(8'h11);
    wait_done(t1);
    chkn("trim centre", TGT, trim, 1);
    chkn("settle longer", 1, (t1 > t0 + t0 / 2), 0);
    wr(`PVC_ADDR_OSC_TRIM, 8'h00);
    #1 chk("trim", 8'h00, {1'b0, trim});
    wr(`PVC_ADDR_OSC_TRIM, {1'b0, TGT});
    rchk(`PVC_ADDR_OSC_TRIM, {1'b0, TGT});
    $display("test calibration done");
    end_of_test;
  end
endmodule // tb_top

// [logic/pvc_defs.vh]
// register offsets, field positions, reset values and timing counts for pll override/calibration
`ifndef PVC_DEFS_VH
`define PVC_DEFS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define PVC_ADDR_PIN_OVERRIDE 8'h58
`define PVC_ADDR_OSC_TRIM     8'h59
`define PVC_ADDR_PLL_HOLD     8'h5C
`define PVC_ADDR_CAL_CONTROL  8'h5D
`define PVC_ADDR_CAL_STATUS   8'h5E

// ****************************************************************
// field positions
// ****************************************************************
`define PVC_OVR_SELECT_BIT    7
`define PVC_OVR_DIV_HI        3
`define PVC_OVR_DIV_LO        2
`define PVC_OVR_SE_BIT        1
`define PVC_OVR_EN_BIT        0
`define PVC_TRIM_HI           6
`define PVC_SETTLE_HI         6
`define PVC_SETTLE_LO         4
`define PVC_CAL_EN_BIT        0
`define PVC_HOLD_BIT          0

// ****************************************************************
// reset values
// ****************************************************************
`define PVC_RST_PIN_OVERRIDE  8'h00
`define PVC_RST_OSC_TRIM      7'h00
`define PVC_RST_PLL_HOLD      1'h0
`define PVC_RST_CAL_CONTROL   8'h40

// ****************************************************************
// timing: settle unit, in ns, and its cycle count at 125 MHz
// ****************************************************************
`define PVC_SETTLE_UNIT_NS    256
`define PVC_CLK_PERIOD_NS     8
`define PVC_SETTLE_UNIT_CYC   (`PVC_SETTLE_UNIT_NS / `PVC_CLK_PERIOD_NS)

`endif

// [logic/pvc_pll_ctrl.v]
// pll pin override, oscillator trim and automatic oscillator calibration
// What this block does
// RULE1: override select 1 takes pll configuration from registers, 0 from pins.
// RULE2: with override, divide field: 0 off, 1 undivided, 2 half, 3 quarter.
// RULE3: without override, divide field ignored; two clock config pins pick output.
// RULE4: with override, single-ended select bit 1 routes single-ended reference in.
// RULE5: with override, pll enable override bit enables the pll in place of pin.
// RULE6: seven-bit trim field written by software and by calibration engine.
// RULE7: tuned trim reads back after calibration for later restore by software.
// RULE8: software must not touch trim while calibration enabled and not done.
// RULE9: software sets hold before pll programming and clears it afterwards.
// RULE10: three-bit settle field, reset 4, larger gives longer wait per trim step.
// RULE11: calibration enable bit arms engine; cleared means no calibration runs.
// RULE12: armed calibration starts when software writes 0 to hold bit while it is set.
// RULE13: engine steps trim to centre oscillator for reference and pll settings.
// RULE14: software changes calibration control only while hold bit is 1.
// RULE15: software writes reserved fields as zero.
// RULE16: done flag set when calibration completes or is skipped by disable.
// RULE17: done flag cleared when a new calibration starts.
`timescale 1ns/1ns
`include "pvc_defs.vh"
module pvc_pll_ctrl #(
  parameter TRIM_W = 7
) (
  input  wire              core_clk_i,
  input  wire              rst_n_i,
  // register port
  input  wire              reg_wr_i,
  input  wire              reg_rd_i,
  input  wire [7:0]        reg_addr_i,
  input  wire [7:0]        reg_wdata_i,
  output reg  [7:0]        reg_rdata_o,
  // configuration pins
  input  wire              pll_enable_pin_i,
  input  wire              ref_type_select_pin_i,
  input  wire              clock_cfg_pin_a_i,
  input  wire              clock_cfg_pin_b_i,
  // reference clock and oscillator comparator
  input  wire              pll_ref_clk_i,
  input  wire              osc_too_fast_i,
  // pll controls
  output wire              pll_enable_o,
  output wire              single_ended_ref_select_o,
  output wire              pll_program_hold_o,
  output wire [TRIM_W-1:0] osc_freq_trim_o,
  output wire              osc_cal_done_o,
  output wire              ref_clock_out_c_o
);

  // ****************************************************************
  // engine states
  // ****************************************************************
  localparam ST_IDLE   = 2'h0;
  localparam ST_SETTLE = 2'h1;
  localparam ST_DECIDE = 2'h2;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg  [3:0] pin_s1_r;
  reg  [3:0] pin_s2_r;

  // pins are asynchronous; first stage feeds only the second
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {clock_cfg_pin_b_i, clock_cfg_pin_a_i,
                   ref_type_select_pin_i, pll_enable_pin_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  // comparator is analog; synchronise the same way
  reg        fast_s1_r;
  reg        fast_s2_r;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fast_s1_r <= 1'b0;
      fast_s2_r <= 1'b0;
    end else begin
      fast_s1_r <= osc_too_fast_i;
      fast_s2_r <= fast_s1_r;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [7:0]        ovr_r;
  reg  [TRIM_W-1:0] trim_r;
  reg               hold_r;
  reg  [7:0]        cal_ctl_r;
  reg               done_r;
  reg  [1:0]        state_r;
  reg  [TRIM_W-1:0] step_r;
  reg  [15:0]       wait_r;

  wire ovr_sel  = ovr_r[`PVC_OVR_SELECT_BIT];
  wire cal_en   = cal_ctl_r[`PVC_CAL_EN_BIT];
  wire [2:0] settle = cal_ctl_r[`PVC_SETTLE_HI:`PVC_SETTLE_LO];
  wire wr_hold  = reg_wr_i && (reg_addr_i == `PVC_ADDR_PLL_HOLD);
  // hold released by a write of 0 while it was set
  wire release_hold = wr_hold && hold_r && !reg_wdata_i[`PVC_HOLD_BIT];

  // settle wait: one unit doubled per settle code; code 7 still fits 16 bits
  function [15:0] settle_cycles;
    input [2:0]  s;
    reg   [31:0] full;
    begin
      full          = `PVC_SETTLE_UNIT_CYC << s;
      settle_cycles = full[15:0];
    end
  endfunction

  // software writes; reserved bits of override and control are stored as written, hold keeps only bit 0
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_r     <= `PVC_RST_PIN_OVERRIDE;
      hold_r    <= `PVC_RST_PLL_HOLD;
      cal_ctl_r <= `PVC_RST_CAL_CONTROL;          // RULE10
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PVC_ADDR_PIN_OVERRIDE: ovr_r     <= reg_wdata_i;
        `PVC_ADDR_PLL_HOLD:     hold_r    <= reg_wdata_i[`PVC_HOLD_BIT];
        `PVC_ADDR_CAL_CONTROL:  cal_ctl_r <= reg_wdata_i;
        default:                ovr_r     <= ovr_r;
      endcase
    end
  end

  // ****************************************************************
  // calibration engine: binary search of the trim
  // ****************************************************************
  // writing 1 to the hold bit aborts any run in progress
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      trim_r  <= `PVC_RST_OSC_TRIM;
      step_r  <= {TRIM_W{1'b0}};
      wait_r  <= 16'h0000;
      done_r  <= 1'b0;
    end else if (release_hold) begin
      if (cal_en) begin                                // RULE11 RULE12
        state_r <= ST_SETTLE;
        trim_r  <= {1'b1, {(TRIM_W-1){1'b0}}};         // RULE13
        step_r  <= {2'b01, {(TRIM_W-2){1'b0}}};
        wait_r  <= settle_cycles(settle);              // RULE10
        done_r  <= 1'b0;                               // RULE17
      end else begin
        done_r  <= 1'b1;                               // RULE16
      end
    end else if (wr_hold && reg_wdata_i[`PVC_HOLD_BIT]) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // software trim write, kept off while a run is busy
          if (reg_wr_i && (reg_addr_i == `PVC_ADDR_OSC_TRIM)) begin
            trim_r <= reg_wdata_i[`PVC_TRIM_HI:0];     // RULE6
          end
        end
        ST_SETTLE: begin
          if (wait_r <= 16'h0001) begin
            state_r <= ST_DECIDE;
          end else begin
            wait_r <= wait_r - 16'h0001;               // RULE10
          end
        end
        ST_DECIDE: begin
          // lower trim by step_r if too fast, raise it by step_r otherwise; at step 0 lower by one only if too fast
          if (step_r == {TRIM_W{1'b0}}) begin
            if (fast_s2_r) begin
              trim_r <= trim_r - {{(TRIM_W-1){1'b0}}, 1'b1};
            end
            state_r <= ST_IDLE;
            done_r  <= 1'b1;                           // RULE16 RULE7
          end else begin
            if (fast_s2_r) begin
              trim_r <= trim_r - step_r;               // RULE13
            end else begin
              trim_r <= trim_r + step_r;               // RULE13
            end
            step_r  <= step_r >> 1;
            wait_r  <= settle_cycles(settle);
            state_r <= ST_SETTLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // register read-back
  // ****************************************************************
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `PVC_ADDR_PIN_OVERRIDE: reg_rdata_o <= ovr_r;
        `PVC_ADDR_OSC_TRIM:     reg_rdata_o <= {1'b0, trim_r};   // RULE7
        `PVC_ADDR_PLL_HOLD:     reg_rdata_o <= {7'h00, hold_r};
        `PVC_ADDR_CAL_CONTROL:  reg_rdata_o <= cal_ctl_r;
        `PVC_ADDR_CAL_STATUS:   reg_rdata_o <= {7'h00, done_r};
        default:                reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // override muxing
  // ****************************************************************
  wire [1:0] pin_div = {pin_s2_r[3], pin_s2_r[2]};               // RULE3
  wire [1:0] div_sel = ovr_sel ? ovr_r[`PVC_OVR_DIV_HI:`PVC_OVR_DIV_LO]
                               : pin_div;                        // RULE1 RULE2

  assign pll_enable_o = ovr_sel ? ovr_r[`PVC_OVR_EN_BIT] : pin_s2_r[0];  // RULE5
  assign single_ended_ref_select_o = ovr_sel ? ovr_r[`PVC_OVR_SE_BIT]
                                             : pin_s2_r[1];      // RULE4
  assign pll_program_hold_o = hold_r;
  assign osc_freq_trim_o    = trim_r;
  assign osc_cal_done_o     = done_r;

  pvc_ref_div u_ref_div (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ref_clk_i  (pll_ref_clk_i),
    .mode_i     (div_sel),
    .ref_out_o  (ref_clock_out_c_o)
  );

endmodule // pvc_pll_ctrl

// [logic/pvc_ref_div.v]
// reference clock output divider: off, divide by 1, 2 or 4
`timescale 1ns/1ns
module pvc_ref_div (
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  input  wire       ref_clk_i,
  input  wire [1:0] mode_i,
  output reg        ref_out_o
);

  // ****************************************************************
  // synchronise the reference, then divide it
  // ****************************************************************
  reg       ref_s1_r;
  reg       ref_s2_r;
  reg       ref_s3_r;
  reg [1:0] cnt_r;
  wire      rise;

  // ref_s1_r is read only by ref_s2_r
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
    end else begin
      ref_s1_r <= ref_clk_i;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
    end
  end

  assign rise = ref_s2_r & ~ref_s3_r;

  // counter on each reference rise; bit 0 is /2, bit 1 is /4
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 2'h0;
    end else if (rise) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  // output select; registered so the pin sees no glitch
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_out_o <= 1'b0;
    end else begin
      case (mode_i)
        2'h0:    ref_out_o <= 1'b0;      // RULE2
        2'h1:    ref_out_o <= ref_s2_r;  // RULE2
        2'h2:    ref_out_o <= cnt_r[0];  // RULE2
        2'h3:    ref_out_o <= cnt_r[1];  // RULE2
        default: ref_out_o <= 1'b0;
      endcase
    end
  end

endmodule // pvc_ref_div
